/* File: logic/cec_pkg.sv */
package cec_pkg;

   // Register byte offsets, one aligned 32-bit word each
   localparam logic [7:0] CEC_OFS_INSTANCE_SELECT = 8'h00;
   localparam logic [7:0] CEC_OFS_EVENT_CFG = 8'h04;
   localparam logic [7:0] CEC_OFS_CLEAR_CFG = 8'h08;
   localparam logic [7:0] CEC_OFS_START_CFG = 8'h0C;
   localparam logic [7:0] CEC_OFS_COMMAND = 8'h10;
   localparam logic [7:0] CEC_OFS_PRESENT_COUNT = 8'h14;
   localparam logic [7:0] CEC_OFS_COUNT_LATCHED = 8'h18;
   localparam logic [7:0] CEC_OFS_TERMINAL_COUNT = 8'h1C;
   localparam logic [7:0] CEC_OFS_COUNTING_STATE = 8'h20;

   // Field positions
   localparam int CEC_EDGE_BIT = 0;
   localparam int CEC_SRC_LSB = 0;
   localparam int CEC_SRC_W = 3;
   localparam int CEC_COND_LSB = 4;
   localparam int CEC_COND_W = 3;
   localparam int CEC_EVSRC_LSB = 4;
   localparam int CEC_CMD_CLEAR_BIT = 0;

   // Widths
   localparam int CEC_CNT_W = 32;
   localparam int CEC_NUM_IN = 6;

   // Synchronised input vector positions
   localparam int CEC_IN_FRAME = 0;
   localparam int CEC_IN_EXPOSURE = 1;
   localparam int CEC_IN_LINE = 2;
   localparam int CEC_IN_HOSTLINK = 3;
   localparam int CEC_IN_EXTERNAL = 4;
   localparam int CEC_IN_ACQ = 5;

   // Reset values and the smallest accepted terminal count
   localparam logic [31:0] CEC_TERMINAL_RST = 32'hFFFF_FFFF;
   localparam logic [31:0] CEC_TERMINAL_MIN = 32'h0000_0001;
   localparam logic [2:0] CEC_SRC_RST = 3'h0;
   localparam logic [2:0] CEC_COND_RST = 3'h0;
   localparam logic [0:0] CEC_INSTANCE_FIRST = 1'h0;

   // Count input choices
   typedef enum logic [2:0] {
      CEC_CNT_OFF = 3'h0,
      CEC_CNT_FRAME = 3'h1,
      CEC_CNT_EXPOSURE = 3'h2,
      CEC_CNT_LINE = 3'h3,
      CEC_CNT_HOSTLINK = 3'h4,
      CEC_CNT_EXTERNAL = 3'h5
   } cec_count_src_t;

   // Clear and start input choices
   typedef enum logic [2:0] {
      CEC_CTL_OFF = 3'h0,
      CEC_CTL_FRAME = 3'h1,
      CEC_CTL_EXPOSURE = 3'h2,
      CEC_CTL_ACQ = 3'h3,
      CEC_CTL_EXTERNAL = 3'h4
   } cec_ctl_src_t;

   // Clear and start conditions
   typedef enum logic [2:0] {
      CEC_COND_RISE = 3'h0,
      CEC_COND_FALL = 3'h1,
      CEC_COND_ANY = 3'h2,
      CEC_COND_HIGH = 3'h3,
      CEC_COND_LOW = 3'h4
   } cec_cond_t;

   // Counting state, Gray along idle -> active -> done
   typedef enum logic [1:0] {
      CEC_ST_IDLE = 2'b00,
      CEC_ST_ACTIVE = 2'b01,
      CEC_ST_DONE = 2'b11
   } cec_state_t;

endpackage

/* File: logic/cec_top.sv */
// Functional notes
// - Instance select holds only the first instance
// - Rising count edge increments on low-to-high
// - Falling count edge increments on high-to-low
// - Count input selectable; off stops counting
// - Clear input selectable; off disables hardware clear
// - Rising clear condition clears on rising edge
// - Falling clear condition clears on falling edge
// - Any-edge clear condition clears on both edges
// - Level-high clear holds count cleared while high
// - Level-low clear holds count cleared while low
// - Software clear command clears; counting resumes unless an edge start condition re-arms
// - Present count readable at any time
// - Software clear latches previous count value
// - Terminal event count 1 to all-ones
// - Counting state readable by software
// - Start input selectable; off disables start trigger
// - Rising start condition starts on rising edge
// - Falling start condition starts on falling edge
// - Any-edge start condition starts on both edges
// - Level-high start holds count cleared while high
`timescale 1ns/1ps

module cec_top
   import cec_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rdata,
   input wire logic frame_readout_window,
   input wire logic exposure_window,
   input wire logic line_period_pulse,
   input wire logic host_link_trigger,
   input wire logic external_trigger_input,
   input wire logic acquisition_window,
   output logic [31:0] present_count,
   output logic [1:0] counting_state
);

   // Picks a clear or start source from the synchronised vector
   function automatic logic ctl_pick(input logic [2:0] sel, input logic [CEC_NUM_IN-1:0] v);
      logic r;
      r = 1'b0;
      unique case (sel)
         CEC_CTL_FRAME: r = v[CEC_IN_FRAME];
         CEC_CTL_EXPOSURE: r = v[CEC_IN_EXPOSURE];
         CEC_CTL_ACQ: r = v[CEC_IN_ACQ];
         CEC_CTL_EXTERNAL: r = v[CEC_IN_EXTERNAL];
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Edge or level condition on a selected source, shared by clear and start
   function automatic logic cond_hit(input logic [2:0] cond, input logic cur, input logic prev);
      logic r;
      r = 1'b0;
      unique case (cond)
         CEC_COND_RISE: r = cur & ~prev;
         CEC_COND_FALL: r = ~cur & prev;
         CEC_COND_ANY: r = cur ^ prev;
         CEC_COND_HIGH: r = cur;
         CEC_COND_LOW: r = ~cur;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // True for the two level conditions
   function automatic logic is_level(input logic [2:0] cond);
      return (cond == CEC_COND_HIGH) || (cond == CEC_COND_LOW);
   endfunction

   logic [CEC_NUM_IN-1:0] raw_in;
   logic [CEC_NUM_IN-1:0] sync1_q;
   logic [CEC_NUM_IN-1:0] sync2_q;
   logic [CEC_NUM_IN-1:0] prev_q;
   logic [0:0] instance_q;
   logic count_fall_q;
   logic [2:0] count_src_q;
   logic [2:0] clear_src_q;
   logic [2:0] clear_cond_q;
   logic [2:0] start_src_q;
   logic [2:0] start_cond_q;
   logic [31:0] terminal_q;
   logic [31:0] count_q;
   logic [31:0] count_d;
   logic [31:0] latched_q;
   cec_state_t state_q;
   cec_state_t state_d;
   logic [31:0] rdata_q;
   logic sw_clear;
   logic ev_cur;
   logic ev_prev;
   logic ev_hit;
   logic clr_cur;
   logic clr_prev;
   logic clr_hit;
   logic st_cur;
   logic st_prev;
   logic st_hit;
   logic st_hold;
   logic any_clear;
   logic [31:0] count_inc;

   assign raw_in[CEC_IN_FRAME] = frame_readout_window;
   assign raw_in[CEC_IN_EXPOSURE] = exposure_window;
   assign raw_in[CEC_IN_LINE] = line_period_pulse;
   assign raw_in[CEC_IN_HOSTLINK] = host_link_trigger;
   assign raw_in[CEC_IN_EXTERNAL] = external_trigger_input;
   assign raw_in[CEC_IN_ACQ] = acquisition_window;

   // Two-flop synchroniser per source plus a history flop for edges
   genvar gi;
   generate
      for (gi = 0; gi < CEC_NUM_IN; gi++)
      begin : g_sync
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
               prev_q[gi] <= 1'b0;
            end
            else
            begin
               sync1_q[gi] <= raw_in[gi];
               sync2_q[gi] <= sync1_q[gi];
               prev_q[gi] <= sync2_q[gi];
            end
         end
      end
   endgenerate

   // Count input pick; off yields a constant so no edge can ever occur
   always_comb
   begin
      ev_cur = 1'b0;
      ev_prev = 1'b0;
      unique case (count_src_q)
         CEC_CNT_FRAME:
         begin
            ev_cur = sync2_q[CEC_IN_FRAME];
            ev_prev = prev_q[CEC_IN_FRAME];
         end
         CEC_CNT_EXPOSURE:
         begin
            ev_cur = sync2_q[CEC_IN_EXPOSURE];
            ev_prev = prev_q[CEC_IN_EXPOSURE];
         end
         CEC_CNT_LINE:
         begin
            ev_cur = sync2_q[CEC_IN_LINE];
            ev_prev = prev_q[CEC_IN_LINE];
         end
         CEC_CNT_HOSTLINK:
         begin
            ev_cur = sync2_q[CEC_IN_HOSTLINK];
            ev_prev = prev_q[CEC_IN_HOSTLINK];
         end
         CEC_CNT_EXTERNAL:
         begin
            ev_cur = sync2_q[CEC_IN_EXTERNAL];
            ev_prev = prev_q[CEC_IN_EXTERNAL];
         end
         default:
         begin
            ev_cur = 1'b0;
            ev_prev = 1'b0;
         end
      endcase
   end

   // Event edge according to the chosen count edge
   assign ev_hit = count_fall_q ? (~ev_cur & ev_prev) : (ev_cur & ~ev_prev);

   // Hardware clear; an off source never hits
   assign clr_cur = ctl_pick(clear_src_q, sync2_q);
   assign clr_prev = ctl_pick(clear_src_q, prev_q);
   assign clr_hit = (clear_src_q != CEC_CTL_OFF) &&
      cond_hit(clear_cond_q, clr_cur, clr_prev);

   // Start trigger; level conditions hold the count cleared instead of arming
   assign st_cur = ctl_pick(start_src_q, sync2_q);
   assign st_prev = ctl_pick(start_src_q, prev_q);
   assign st_hit = (start_src_q != CEC_CTL_OFF) && !is_level(start_cond_q) &&
      cond_hit(start_cond_q, st_cur, st_prev);
   assign st_hold = (start_src_q != CEC_CTL_OFF) && is_level(start_cond_q) &&
      cond_hit(start_cond_q, st_cur, st_prev);

   assign sw_clear = wr_stb && (addr == CEC_OFS_COMMAND) && wdata[CEC_CMD_CLEAR_BIT];
   assign any_clear = sw_clear || clr_hit || st_hold;
   assign count_inc = count_q + 32'h0000_0001;

   // Next count and state; any clear wins over a same-cycle event
   always_comb
   begin
      count_d = count_q;
      state_d = state_q;
      if (any_clear)
      begin
         count_d = 32'h0000_0000;
         // Edge-started counters re-arm and wait; others resume at once
         if ((start_src_q == CEC_CTL_OFF) || is_level(start_cond_q))
         begin
            state_d = CEC_ST_ACTIVE;
         end
         else
         begin
            state_d = CEC_ST_IDLE;
         end
      end
      else
      begin
         unique case (state_q)
            CEC_ST_IDLE:
            begin
               if (st_hit || (start_src_q == CEC_CTL_OFF))
               begin
                  state_d = CEC_ST_ACTIVE;
               end
            end
            CEC_ST_ACTIVE:
            begin
               if (count_q >= terminal_q)
               begin
                  state_d = CEC_ST_DONE;
               end
               else if (ev_hit)
               begin
                  count_d = count_inc;
                  if (count_inc >= terminal_q)
                  begin
                     state_d = CEC_ST_DONE;
                  end
               end
            end
            CEC_ST_DONE:
            begin
               state_d = CEC_ST_DONE;
            end
            default:
            begin
               state_d = CEC_ST_IDLE;
            end
         endcase
      end
   end

   // Count and state registers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         count_q <= 32'h0000_0000;
         state_q <= CEC_ST_IDLE;
      end
      else
      begin
         count_q <= count_d;
         state_q <= state_d;
      end
   end

   // Value at clear is taken only by the software command
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         latched_q <= 32'h0000_0000;
      end
      else if (sw_clear)
      begin
         latched_q <= count_q;
      end
   end

   // Configuration writes; out-of-range values are dropped, not clipped
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         instance_q <= CEC_INSTANCE_FIRST;
         count_fall_q <= 1'b0;
         count_src_q <= CEC_SRC_RST;
         clear_src_q <= CEC_SRC_RST;
         clear_cond_q <= CEC_COND_RST;
         start_src_q <= CEC_SRC_RST;
         start_cond_q <= CEC_COND_RST;
         terminal_q <= CEC_TERMINAL_RST;
      end
      else if (wr_stb)
      begin
         unique case (addr)
            CEC_OFS_INSTANCE_SELECT:
            begin
               instance_q <= CEC_INSTANCE_FIRST;
            end
            CEC_OFS_EVENT_CFG:
            begin
               count_fall_q <= wdata[CEC_EDGE_BIT];
               if (wdata[CEC_EVSRC_LSB +: CEC_SRC_W] <= CEC_CNT_EXTERNAL)
               begin
                  count_src_q <= wdata[CEC_EVSRC_LSB +: CEC_SRC_W];
               end
            end
            CEC_OFS_CLEAR_CFG:
            begin
               if (wdata[CEC_SRC_LSB +: CEC_SRC_W] <= CEC_CTL_EXTERNAL)
               begin
                  clear_src_q <= wdata[CEC_SRC_LSB +: CEC_SRC_W];
               end
               if (wdata[CEC_COND_LSB +: CEC_COND_W] <= CEC_COND_LOW)
               begin
                  clear_cond_q <= wdata[CEC_COND_LSB +: CEC_COND_W];
               end
            end
            CEC_OFS_START_CFG:
            begin
               if (wdata[CEC_SRC_LSB +: CEC_SRC_W] <= CEC_CTL_EXTERNAL)
               begin
                  start_src_q <= wdata[CEC_SRC_LSB +: CEC_SRC_W];
               end
               if (wdata[CEC_COND_LSB +: CEC_COND_W] <= CEC_COND_LOW)
               begin
                  start_cond_q <= wdata[CEC_COND_LSB +: CEC_COND_W];
               end
            end
            CEC_OFS_TERMINAL_COUNT:
            begin
               if (wdata >= CEC_TERMINAL_MIN)
               begin
                  terminal_q <= wdata;
               end
            end
            default:
            begin
               instance_q <= instance_q;
            end
         endcase
      end
   end

   // Read data stands for the cycle after the strobe only; unmapped reads zero
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else if (rd_stb)
      begin
         unique case (addr)
            CEC_OFS_INSTANCE_SELECT: rdata_q <= {31'h0000_0000, instance_q};
            CEC_OFS_EVENT_CFG: rdata_q <= {25'h000_0000, count_src_q, 3'h0, count_fall_q};
            CEC_OFS_CLEAR_CFG: rdata_q <= {25'h000_0000, clear_cond_q, 1'b0, clear_src_q};
            CEC_OFS_START_CFG: rdata_q <= {25'h000_0000, start_cond_q, 1'b0, start_src_q};
            CEC_OFS_PRESENT_COUNT: rdata_q <= count_q;
            CEC_OFS_COUNT_LATCHED: rdata_q <= latched_q;
            CEC_OFS_TERMINAL_COUNT: rdata_q <= terminal_q;
            CEC_OFS_COUNTING_STATE: rdata_q <= {30'h0000_0000, state_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
      else
      begin
         rdata_q <= 32'h0000_0000;
      end
   end

   assign rdata = rdata_q;
   assign present_count = count_q;
   assign counting_state = state_q;

endmodule // cec_top

/* File: testbench/cec_top_assertions.sv */
`timescale 1ns/1ps

module cec_top_checker
   import cec_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [31:0] rdata,
   input wire logic [31:0] present_count,
   input wire logic [1:0] counting_state
);
   logic [31:0] latch_q;
   logic clr;

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // Software clear strobe as seen on the register port
   assign clr = wr_stb && addr == CEC_OFS_COMMAND && wdata[CEC_CMD_CLEAR_BIT];

   // Own copy of the count taken at a software clear, to judge the latched read
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         latch_q <= 32'h0000_0000;
      else if (clr)
         latch_q <= present_count;
   end

   // Read data only in the cycle after a read strobe, so stale data never leaks
   a_rdata_idle_zero: assert property (rdata != 32'h0000_0000 |-> $past(rd_stb))
      else $error("read data seen without a read strobe");
   a_count_read_value: assert property (rd_stb && addr == CEC_OFS_PRESENT_COUNT |=>
      rdata == $past(present_count)) else $error("count read differs from count");
   a_latched_read_value: assert property (rd_stb && addr == CEC_OFS_COUNT_LATCHED |=>
      rdata == $past(latch_q)) else $error("latched read differs from count at clear");
   a_state_read_value: assert property (rd_stb && addr == CEC_OFS_COUNTING_STATE |=>
      rdata == {30'h0, $past(counting_state)}) else $error("state read differs");
   a_fixed_zero_read: assert property (rd_stb && (addr == CEC_OFS_INSTANCE_SELECT ||
      addr == CEC_OFS_COMMAND) |=> rdata == 32'h0000_0000) else $error("fixed read not 0");
   a_soft_clear_zero: assert property (clr |=> present_count == 32'h0000_0000)
      else $error("count not cleared by software clear");
   a_count_single_step: assert property ($changed(present_count) |->
      present_count == 32'h0000_0000 || present_count == $past(present_count) + 32'h1)
      else $error("count moved by other than one");
   a_done_count_frozen: assert property (counting_state == CEC_ST_DONE && !clr |=>
      present_count == 32'h0000_0000 || $stable(present_count)) else $error("done but counting");
   a_state_code_legal: assert property (counting_state != 2'b10)
      else $error("illegal counting state");

   // Main scenarios reached
   c_soft_clear: cover property (clr);
   c_done_seen: cover property (counting_state == CEC_ST_DONE);
   c_latched_read: cover property (rd_stb && addr == CEC_OFS_COUNT_LATCHED);
endmodule // cec_top_checker

bind cec_top cec_top_checker u_chk (.clk, .rstn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
   .present_count, .counting_state);

/* File: testbench/tb.sv */
`timescale 1ns/1ps

module tb
   import cec_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [5:0] src = 6'h00;
   logic [31:0] rdata;
   logic [31:0] present_count;
   logic [1:0] counting_state;
   int bad_count = 0;
   int cmp_count = 0;
   int i;
   // Expected counts per condition: before the level change (just after it for clear), during it and after it returns
   int clr_exp [5][3] = '{'{0, 2, 2}, '{3, 5, 0}, '{0, 2, 0}, '{0, 0, 0}, '{0, 0, 0}};
   int st_exp [5][3] = '{'{0, 2, 4}, '{0, 0, 2}, '{0, 2, 4}, '{2, 0, 2}, '{2, 0, 2}};
   // Source bit behind clear and start codes 1 to 4: frame, exposure, acquisition, external
   int ctl_bit [4] = '{0, 1, 5, 4};

   // Source bits: frame, exposure, line, host link, external, acquisition
   cec_top dut (
      .clk, .rstn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
      .frame_readout_window(src[0]), .exposure_window(src[1]), .line_period_pulse(src[2]),
      .host_link_trigger(src[3]), .external_trigger_input(src[4]),
      .acquisition_window(src[5]), .present_count, .counting_state
   );

   // 20 MHz clock
   initial forever #25 clk = ~clk;

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      chk(name, rdata, exp);
   endtask

   task automatic cnt(input int e);
      rd(CEC_OFS_PRESENT_COUNT, 32'(e), "count");
   endtask

   task automatic sclr();
      wr(CEC_OFS_COMMAND, 32'h0000_0001);
   endtask

   // Pulses last 4 cycles each way, well above the synchroniser's need
   task automatic pulse(input int k, input int n);
      repeat (n)
      begin
         @(posedge clk);
         src[k] <= ~src[k];
         repeat (4) @(posedge clk);
         src[k] <= ~src[k];
         repeat (4) @(posedge clk);
      end
   endtask

   task automatic lvl(input int k, input logic v);
      @(posedge clk);
      src[k] <= v;
      repeat (6) @(posedge clk);
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Hang guard
   initial
   begin
      #1_000_000;
      bad_count++;
      tally_and_finish();
   end

   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      rd(CEC_OFS_TERMINAL_COUNT, CEC_TERMINAL_RST, "terminal");
      rd(CEC_OFS_COUNTING_STATE, 32'h0000_0001, "state");
      wr(CEC_OFS_INSTANCE_SELECT, 32'h0000_0001);
      rd(CEC_OFS_INSTANCE_SELECT, 32'h0000_0000, "instance");
      rd(8'hFC, 32'h0000_0000, "unmapped");
      // Every count input, with a stray pulse on a neighbour that must not count
      for (i = 1; i <= 5; i++)
      begin
         wr(CEC_OFS_EVENT_CFG, 32'(i) << CEC_EVSRC_LSB);
         sclr();
         if (i > 1)
            rd(CEC_OFS_COUNT_LATCHED, 32'h0000_0003, "latched");
         pulse(i - 1, 3);
         pulse(i % 5, 1);
         cnt(3);
      end
      wr(CEC_OFS_EVENT_CFG, 32'h0000_0051);
      sclr();
      pulse(4, 2);
      cnt(2);
      wr(CEC_OFS_EVENT_CFG, 32'h0000_0000);
      pulse(4, 2);
      cnt(2);
      // Clear conditions on the external input, counting frames
      wr(CEC_OFS_EVENT_CFG, 32'h0000_0010);
      for (i = 0; i < 5; i++)
      begin
         wr(CEC_OFS_CLEAR_CFG, 32'h0000_0000);
         lvl(4, i == 4);
         wr(CEC_OFS_CLEAR_CFG, (32'(i) << CEC_COND_LSB) | 32'h0000_0004);
         sclr();
         pulse(0, 3);
         lvl(4, i != 4);
         cnt(clr_exp[i][0]);
         pulse(0, 2);
         cnt(clr_exp[i][1]);
         lvl(4, i == 4);
         cnt(clr_exp[i][2]);
      end
      wr(CEC_OFS_CLEAR_CFG, 32'h0000_0000);
      pulse(0, 2);
      lvl(4, 1'b0);
      cnt(2);
      // Start conditions on the acquisition input
      for (i = 0; i < 5; i++)
      begin
         wr(CEC_OFS_START_CFG, 32'h0000_0000);
         lvl(5, i == 4);
         wr(CEC_OFS_START_CFG, (32'(i) << CEC_COND_LSB) | 32'h0000_0003);
         sclr();
         rd(CEC_OFS_COUNTING_STATE, (i > 2) ? 32'h0000_0001 : 32'h0000_0000, "idle");
         pulse(0, 2);
         cnt(st_exp[i][0]);
         lvl(5, i != 4);
         pulse(0, 2);
         cnt(st_exp[i][1]);
         lvl(5, i == 4);
         pulse(0, 2);
         cnt(st_exp[i][2]);
      end
      wr(CEC_OFS_START_CFG, 32'h0000_0000);
      // Every clear and start code, counting lines; a wrong pick leaves the count alone
      lvl(5, 1'b0);
      wr(CEC_OFS_EVENT_CFG, 32'h0000_0030);
      for (i = 1; i <= 4; i++)
      begin
         wr(CEC_OFS_CLEAR_CFG, 32'h0000_0030 | 32'(i));
         sclr();
         pulse(2, 2);
         cnt(2);
         lvl(ctl_bit[i - 1], 1'b1);
         cnt(0);
         lvl(ctl_bit[i - 1], 1'b0);
         wr(CEC_OFS_CLEAR_CFG, 32'h0000_0000);
         wr(CEC_OFS_START_CFG, 32'(i));
         sclr();
         pulse(2, 1);
         lvl(ctl_bit[i - 1], 1'b1);
         pulse(2, 2);
         cnt(2);
         wr(CEC_OFS_START_CFG, 32'h0000_0000);
         lvl(ctl_bit[i - 1], 1'b0);
      end
      // Out-of-range codes are dropped while the other field of the word lands
      wr(CEC_OFS_EVENT_CFG, 32'h0000_0061);
      rd(CEC_OFS_EVENT_CFG, 32'h0000_0031, "event cfg");
      wr(CEC_OFS_CLEAR_CFG, 32'h0000_0025);
      rd(CEC_OFS_CLEAR_CFG, 32'h0000_0020, "clear cfg");
      wr(CEC_OFS_CLEAR_CFG, 32'h0000_0000);
      wr(CEC_OFS_EVENT_CFG, 32'h0000_0010);
      // Terminal count: zero refused, then the smallest and a small value
      wr(CEC_OFS_TERMINAL_COUNT, 32'h0000_0000);
      rd(CEC_OFS_TERMINAL_COUNT, CEC_TERMINAL_RST, "terminal zero");
      for (i = 1; i <= 3; i += 2)
      begin
         wr(CEC_OFS_TERMINAL_COUNT, 32'(i));
         sclr();
         pulse(0, 5);
         cnt(i);
         rd(CEC_OFS_COUNTING_STATE, 32'h0000_0003, "done");
      end
      sclr();
      rd(CEC_OFS_COUNT_LATCHED, 32'h0000_0003, "latched");
      rd(CEC_OFS_COUNTING_STATE, 32'h0000_0001, "resumed");
      pulse(0, 1);
      cnt(1);
      // Two sync flops and a history flop: a frame edge counts at the third clock edge
      @(posedge clk);
      src[0] <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("sync latency", present_count, 32'h0000_0001);
      @(posedge clk);
      #1;
      chk("count port", present_count, 32'h0000_0002);
      chk("state port", 32'(counting_state), 32'h0000_0001);
      tally_and_finish();
   end
endmodule // tb
